// [light_idle_consts.svh]
// Offsets, field positions and reset values of the light idle controller.
// Assumes a 4-bit byte address on the register bus, 32-bit words.
`ifndef LIGHT_IDLE_CONSTS_SVH
`define LIGHT_IDLE_CONSTS_SVH

// Register byte offsets
`define OFS_MODE        4'h0
`define OFS_CTRL        4'h4
`define OFS_CLKSEL      4'h8
`define OFS_STATUS      4'hc

// power_save_mode_reg fields
`define MODE_SEL_LO     0
`define MODE_SEL_HI     1
`define MODE_RST        2'h0
`define MODE_LIGHT_IDLE 2'h0

// power_save_control_reg fields
`define CTRL_TRIGGER    0
`define CTRL_PIN_MASK   4
`define CTRL_WDT_MASK   5
`define CTRL_INT_MASK   6
`define CTRL_RST        3'h0

// Clock selection register fields
`define CS_ITIM_LSB     0
`define CS_WDT_LSB      2
`define CS_WATCH_DIV    4
`define CS_SUB_USED     5
`define CS_CSI_LSB      8
`define CS_UART0_EXT    13
`define CS_RST          14'h0000

// Count clock source codes
`define SRC_MAIN        2'h0
`define SRC_OSC_DIV8    2'h1
`define SRC_SUBCLOCK    2'h2

// Status register fields
`define ST_STATE_LSB    0
`define ST_CAUSE_PIN    4
`define ST_CAUSE_WDT    5
`define ST_CAUSE_INT    6
`define ST_REFUSED      7

`define CSI_CHANNELS    5
`define PRIO_W          3

`endif

// [light_idle_pkg.sv]
// Types shared by the light idle controller files.
// Constants live in light_idle_consts.svh.
package light_idle_pkg;

  typedef enum logic [2:0] {
    st_run  = 3'b001,
    st_idle = 3'b010,
    st_wake = 3'b100
  } idle_state_t;

  typedef logic [1:0] clk_src_t;

endpackage

// [wake_decide.sv]
// Wake-up decision for the light idle controller.
// Purely combinational; the caller samples the outputs on its own clock.
`timescale 1ns/10ps
`default_nettype none
`include "light_idle_consts.svh"

module wake_decide (
  // Request sources
  input  wire logic                 nmi_pin_in,
  input  wire logic                 nmi_wdt_in,
  input  wire logic                 mask_req_in,
  input  wire logic [`PRIO_W-1:0]   mask_prio_in,
  // Wake masks
  input  wire logic                 pin_mask_in,
  input  wire logic                 wdt_mask_in,
  input  wire logic                 int_mask_in,
  // CPU state
  input  wire logic                 ie_in,
  input  wire logic                 in_service_in,
  input  wire logic [`PRIO_W-1:0]   service_prio_in,
  // Decision
  output logic                      wake_out,
  output logic                      nmi_wake_out,
  output logic                      take_nmi_out,
  output logic                      take_mask_out,
  output logic                      resume_out
);

  wire logic pin_ok;
  wire logic wdt_ok;
  wire logic int_ok;
  wire logic outranks;

  assign pin_ok = nmi_pin_in & ~pin_mask_in;
  assign wdt_ok = nmi_wdt_in & ~wdt_mask_in;
  assign int_ok = mask_req_in & ~int_mask_in;

  assign nmi_wake_out = pin_ok | wdt_ok;
  assign wake_out     = nmi_wake_out | int_ok;

  // Lower code is higher priority; equal level cannot nest
  assign outranks = ~in_service_in | (mask_prio_in < service_prio_in);

  assign take_nmi_out  = nmi_wake_out;
  assign take_mask_out = ~nmi_wake_out & int_ok & ie_in & outranks;
  assign resume_out    = ~nmi_wake_out & int_ok & ~(ie_in & outranks);

endmodule
`default_nettype wire

// [light_idle_standby_control.sv]
// Light idle standby controller: entry, wake-up and peripheral gating.
// Assumes an Avalon-MM master on clk_in and request lines from the CPU.
//
// Behaviour
// - Pending unmasked request refuses idle entry
// - Any unmasked request ends idle, any priority
// - Waking non-maskable request accepted at once
// - Interrupts disabled: request pends, code resumes
// - Higher handler in service: pend, resume
// - Lower handler in service: accept request
// - Masked requests never end idle
// - CPU, DMA, timers, CRC, controller stop
// - Interval, watchdog timers run on osc/8, subclock
// - Watch timer: subclock or divided main
// - Clocked serial runs on external clock only
// - Other serial stops; uart0 external excepted
// - ADC frozen, result kept
// - DAC frozen, output kept
// - Realtime output stops, pins held
// - Ports and CPU registers held
`timescale 1ns/10ps
`default_nettype none
`include "light_idle_consts.svh"

module light_idle_standby_control (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      srst_in,
  // Avalon-MM slave
  input  wire logic [3:0]                avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [31:0]               avs_writedata_in,
  output logic      [31:0]               avs_readdata_out,
  output logic                           avs_waitrequest_out,
  // Wake sources
  input  wire logic                      nmi_pin_in,
  input  wire logic                      nmi_wdt_in,
  input  wire logic                      mask_req_in,
  input  wire logic [`PRIO_W-1:0]        mask_prio_in,
  // CPU state
  input  wire logic                      interrupts_enabled_in,
  input  wire logic                      in_service_in,
  input  wire logic [`PRIO_W-1:0]        service_prio_in,
  // Wake actions, one-cycle pulses
  output logic                           accept_nmi_out,
  output logic                           accept_mask_out,
  output logic                           resume_out,
  // Mode and clock gating
  output logic                           light_idle_mode_out,
  output logic                           cpu_clk_en_out,
  output logic                           dma_clk_en_out,
  output logic                           timer_clk_en_out,
  output logic                           crc_clk_en_out,
  output logic                           intc_clk_en_out,
  output logic                           interval_timer_clk_en_out,
  output logic                           wdt_clk_en_out,
  output logic                           watch_clk_en_out,
  output logic [`CSI_CHANNELS-1:0]       csi_clk_en_out,
  output logic                           uart0_clk_en_out,
  output logic                           uart_other_clk_en_out,
  output logic                           i2c_clk_en_out,
  output logic                           adc_freeze_out,
  output logic                           dac_freeze_out,
  output logic                           realtime_output_freeze_out,
  output logic                           state_hold_out
);

  light_idle_pkg::idle_state_t state_reg;
  light_idle_pkg::idle_state_t state_next;

  logic [1:0]  mode_reg;
  logic [2:0]  mask_reg;
  logic [13:0] clksel_reg;
  logic [2:0]  cause_reg;
  logic        refused_reg;
  logic        ack_reg;
  logic        pin_meta_reg;
  logic        pin_sync_reg;
  logic        take_nmi_reg;
  logic        take_mask_reg;
  logic        resume_reg;
  logic [31:0] rdata_reg;

  wire logic        req;
  wire logic        wr_fire;
  wire logic        wr_ctrl;
  wire logic        enter_req;
  wire logic        in_idle;
  wire logic        wake;
  wire logic        nmi_wake;
  wire logic        take_nmi;
  wire logic        take_mask;
  wire logic        resume;
  wire logic        sub_used;
  wire logic [31:0] rdata_next;

  // Chooses whether a timer counts while idle
  function automatic logic src_runs(input light_idle_pkg::clk_src_t src,
                                    input logic sub);
    src_runs = (src == `SRC_OSC_DIV8) | (sub & (src == `SRC_SUBCLOCK));
  endfunction

  // Pin request crosses two flops before use
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= nmi_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wake_decide u_decide (
    .nmi_pin_in      (pin_sync_reg),
    .nmi_wdt_in      (nmi_wdt_in),
    .mask_req_in     (mask_req_in),
    .mask_prio_in    (mask_prio_in),
    .pin_mask_in     (mask_reg[0]),
    .wdt_mask_in     (mask_reg[1]),
    .int_mask_in     (mask_reg[2]),
    .ie_in           (interrupts_enabled_in),
    .in_service_in   (in_service_in),
    .service_prio_in (service_prio_in),
    .wake_out        (wake),
    .nmi_wake_out    (nmi_wake),
    .take_nmi_out    (take_nmi),
    .take_mask_out   (take_mask),
    .resume_out      (resume)
  );

  // Bus: one wait cycle, answer on the second edge
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_reg;
  assign wr_fire             = avs_write_in & ack_reg;
  assign wr_ctrl             = wr_fire & (avs_address_in == `OFS_CTRL);

  assign enter_req = wr_ctrl & avs_writedata_in[`CTRL_TRIGGER]
                   & (mode_reg == `MODE_LIGHT_IDLE)
                   & (state_reg == light_idle_pkg::st_run);

  assign in_idle = (state_reg == light_idle_pkg::st_idle);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      light_idle_pkg::st_run: begin
        if (enter_req & ~wake) begin
          state_next = light_idle_pkg::st_idle;
        end
      end
      light_idle_pkg::st_idle: begin
        if (wake) begin
          state_next = light_idle_pkg::st_wake;
        end
      end
      light_idle_pkg::st_wake: begin
        state_next = light_idle_pkg::st_run;
      end
      default: begin
        state_next = light_idle_pkg::st_run;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= light_idle_pkg::st_run;
    end else begin
      state_reg <= state_next;
    end
  end

  // Wake actions latched on the idle exit edge
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      take_nmi_reg  <= 1'b0;
      take_mask_reg <= 1'b0;
      resume_reg    <= 1'b0;
    end else begin
      take_nmi_reg  <= in_idle & wake & take_nmi;
      take_mask_reg <= in_idle & wake & take_mask;
      resume_reg    <= in_idle & wake & resume;
    end
  end

  assign accept_nmi_out  = take_nmi_reg;
  assign accept_mask_out = take_mask_reg;
  assign resume_out      = resume_reg;

  // Registers; trigger bit is not stored and reads as zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mode_reg   <= `MODE_RST;
      mask_reg   <= `CTRL_RST;
      clksel_reg <= `CS_RST;
    end else if (wr_fire) begin
      if (avs_address_in == `OFS_MODE) begin
        mode_reg <= avs_writedata_in[`MODE_SEL_HI:`MODE_SEL_LO];
      end
      if (wr_ctrl) begin
        mask_reg <= avs_writedata_in[`CTRL_INT_MASK:`CTRL_PIN_MASK];
      end
      if (avs_address_in == `OFS_CLKSEL) begin
        clksel_reg <= avs_writedata_in[13:0];
      end
    end
  end

  // Cause and refusal flags for software
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cause_reg   <= 3'h0;
      refused_reg <= 1'b0;
    end else begin
      if (in_idle & wake) begin
        cause_reg <= {mask_req_in & ~mask_reg[2],
                      nmi_wdt_in & ~mask_reg[1],
                      pin_sync_reg & ~mask_reg[0]};
      end
      if (enter_req) begin
        refused_reg <= wake;
      end
    end
  end

  assign rdata_next =
    (avs_address_in == `OFS_MODE)   ? {30'h0, mode_reg} :
    (avs_address_in == `OFS_CTRL)   ? {25'h0, mask_reg, 4'h0} :
    (avs_address_in == `OFS_CLKSEL) ? {18'h0, clksel_reg} :
    (avs_address_in == `OFS_STATUS) ? {24'h0, refused_reg, cause_reg,
                                       1'b0, state_reg} :
                                      32'h0;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg   <= req & ~ack_reg;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_out = rdata_reg;

  assign sub_used = clksel_reg[`CS_SUB_USED];

  assign light_idle_mode_out = in_idle;
  assign cpu_clk_en_out      = ~in_idle;
  assign dma_clk_en_out      = ~in_idle;
  assign timer_clk_en_out    = ~in_idle;
  assign crc_clk_en_out      = ~in_idle;
  assign intc_clk_en_out     = ~in_idle;

  assign interval_timer_clk_en_out = ~in_idle
    | src_runs(clksel_reg[`CS_ITIM_LSB+1:`CS_ITIM_LSB], sub_used);
  assign wdt_clk_en_out = ~in_idle
    | src_runs(clksel_reg[`CS_WDT_LSB+1:`CS_WDT_LSB], sub_used);

  assign watch_clk_en_out = ~in_idle | sub_used
                          | clksel_reg[`CS_WATCH_DIV];

  assign csi_clk_en_out = {`CSI_CHANNELS{~in_idle}}
    | clksel_reg[`CS_CSI_LSB+`CSI_CHANNELS-1:`CS_CSI_LSB];

  assign uart0_clk_en_out      = ~in_idle | clksel_reg[`CS_UART0_EXT];
  assign uart_other_clk_en_out = ~in_idle;
  assign i2c_clk_en_out        = ~in_idle;

  assign adc_freeze_out = in_idle;
  assign dac_freeze_out = in_idle;
  assign realtime_output_freeze_out = in_idle;
  assign state_hold_out = in_idle;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  chk_refuse_entry: assert property (
    enter_req & wake |=> state_reg == light_idle_pkg::st_run
  ) else $error("idle entered with request pending");

  chk_wake_exit: assert property (
    in_idle & wake |=> state_reg == light_idle_pkg::st_wake ##1
      state_reg == light_idle_pkg::st_run
  ) else $error("idle not left on request");

  chk_nmi_accept: assert property (
    in_idle & nmi_wake |=> accept_nmi_out & ~accept_mask_out & ~resume_out
  ) else $error("non-maskable wake not accepted");

  chk_disabled_pending: assert property (
    in_idle & wake & ~nmi_wake & ~interrupts_enabled_in
      |=> resume_out & ~accept_mask_out
  ) else $error("request accepted with interrupts disabled");

  chk_higher_hold: assert property (
    in_idle & wake & ~nmi_wake & interrupts_enabled_in & in_service_in
      & (service_prio_in < mask_prio_in) |=> resume_out
  ) else $error("request accepted over higher handler");

  chk_lower_accept: assert property (
    in_idle & wake & ~nmi_wake & interrupts_enabled_in & in_service_in
      & (mask_prio_in < service_prio_in) |=> accept_mask_out
  ) else $error("request not accepted over lower handler");

  chk_masked_ignore: assert property (
    in_idle & (&mask_reg) |=> $stable(state_reg)
  ) else $error("masked request ended idle");

  chk_cpu_stopped: assert property (
    $rose(light_idle_mode_out) |-> ~cpu_clk_en_out & ~dma_clk_en_out
      & ~crc_clk_en_out
  ) else $error("core unit clocked in idle");

  chk_timer_gate: assert property (
    in_idle & (clksel_reg[1:0] == `SRC_MAIN) |-> ~interval_timer_clk_en_out
  ) else $error("interval timer runs on main clock in idle");

  chk_freeze_span: assert property (
    in_idle |-> adc_freeze_out & dac_freeze_out & realtime_output_freeze_out
  ) else $error("converter not frozen in idle");

  chk_reset_exit: assert property (
    @(posedge clk_in) disable iff (1'b0)
    srst_in |=> state_reg == light_idle_pkg::st_run & ~accept_nmi_out
  ) else $error("reset did not end idle");

endmodule
`default_nettype wire

// [irq_source_model.sv]
// Request sources and CPU acknowledge logic facing the idle controller.
// Assumes the bench raises or drops requests off the sampling edge.
`timescale 1ns/10ps
`default_nettype none

module irq_source_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // Bench commands, bit0 pin, bit1 watchdog, bit2 maskable
  input  wire logic [2:0] raise_in,
  input  wire logic       drop_in,
  // Controller answers
  input  wire logic       accept_nmi_in,
  input  wire logic       accept_mask_in,
  // Request lines
  output logic            nmi_pin_out,
  output logic            nmi_wdt_out,
  output logic            mask_req_out
);
  always_ff @(posedge clk_in) begin
    if (srst_in || drop_in) begin
      nmi_pin_out  <= 1'b0;
      nmi_wdt_out  <= 1'b0;
      mask_req_out <= 1'b0;
    end else begin
      nmi_pin_out  <= (nmi_pin_out | raise_in[0]) & ~accept_nmi_in;
      nmi_wdt_out  <= (nmi_wdt_out | raise_in[1]) & ~accept_nmi_in;
      mask_req_out <= (mask_req_out | raise_in[2]) & ~accept_mask_in;
    end
  end
endmodule

`default_nettype wire

// [light_idle_standby_control_tb_top.sv]
// Self-checking bench for the light idle standby controller.
// Assumes the controller, its package, header and request model.
`timescale 1ns/10ps
`default_nettype none
`include "light_idle_consts.svh"

module light_idle_standby_control_tb_top;
  typedef struct packed {
    logic        ie;
    logic        svc;
    logic [2:0]  sprio;
    logic [2:0]  src;
    logic [2:0]  mprio;
    logic [13:0] cs;
    logic [2:0]  act;
    logic [8:0]  gate;
    logic [2:0]  cause;
  } row_t;

  localparam row_t ROWS [7] = '{
    '{1'b0, 1'b0, 3'h0, 3'h1, 3'h0, 14'h3519, 3'h4, 9'h16b, 3'h1},
    '{1'b1, 1'b0, 3'h0, 3'h2, 3'h0, 14'h0022, 3'h4, 9'h140, 3'h2},
    '{1'b0, 1'b0, 3'h0, 3'h4, 3'h2, 14'h0000, 3'h1, 9'h000, 3'h4},
    '{1'b1, 1'b1, 3'h1, 3'h4, 3'h3, 14'h0004, 3'h1, 9'h080, 3'h4},
    '{1'b1, 1'b1, 3'h5, 3'h4, 3'h2, 14'h0028, 3'h2, 9'h0c0, 3'h4},
    '{1'b1, 1'b0, 3'h0, 3'h4, 3'h7, 14'h1f00, 3'h2, 9'h03e, 3'h4},
    '{1'b1, 1'b1, 3'h4, 3'h4, 3'h4, 14'h0000, 3'h1, 9'h000, 3'h4}};
  localparam logic [3:0]  OFS [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
  localparam logic [31:0] RVAL [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};

  logic        clk_in, srst_in, avs_read_in, avs_write_in, drop;
  logic        nmi_pin_in, nmi_wdt_in, mask_req_in, in_service_in;
  logic        interrupts_enabled_in, accept_nmi_out, accept_mask_out;
  logic        resume_out, light_idle_mode_out, avs_waitrequest_out;
  logic        cpu_clk_en_out, dma_clk_en_out, timer_clk_en_out;
  logic        crc_clk_en_out, intc_clk_en_out, interval_timer_clk_en_out;
  logic        wdt_clk_en_out, watch_clk_en_out, uart0_clk_en_out;
  logic        uart_other_clk_en_out, i2c_clk_en_out, adc_freeze_out;
  logic        dac_freeze_out, realtime_output_freeze_out, state_hold_out;
  logic [3:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic [2:0]  mask_prio_in, service_prio_in, raise, act;
  logic [4:0]  csi_clk_en_out;
  int          err_total, tests_run;
  row_t        r;
  wire  [6:0]  stop_v = {cpu_clk_en_out, dma_clk_en_out, timer_clk_en_out,
                         crc_clk_en_out, intc_clk_en_out, i2c_clk_en_out,
                         uart_other_clk_en_out};

  light_idle_standby_control i_dut (.clk_in, .srst_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .nmi_pin_in, .nmi_wdt_in, .mask_req_in,
    .mask_prio_in, .interrupts_enabled_in, .in_service_in,
    .service_prio_in, .accept_nmi_out, .accept_mask_out, .resume_out,
    .light_idle_mode_out, .cpu_clk_en_out, .dma_clk_en_out,
    .timer_clk_en_out, .crc_clk_en_out, .intc_clk_en_out,
    .interval_timer_clk_en_out, .wdt_clk_en_out, .watch_clk_en_out,
    .csi_clk_en_out, .uart0_clk_en_out, .uart_other_clk_en_out,
    .i2c_clk_en_out, .adc_freeze_out, .dac_freeze_out,
    .realtime_output_freeze_out, .state_hold_out);

  irq_source_model i_src (.clk_in, .srst_in, .raise_in(raise),
    .drop_in(drop), .accept_nmi_in(accept_nmi_out),
    .accept_mask_in(accept_mask_out), .nmi_pin_out(nmi_pin_in),
    .nmi_wdt_out(nmi_wdt_in), .mask_req_out(mask_req_in));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Hold the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= ~w;
    do begin
      @(posedge clk_in);
      n++;
      if (n > 20) begin
        err_total++;
        tally_and_finish();
      end
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic fire(input logic [2:0] s, input logic dr);
    @(posedge clk_in);
    raise <= s;
    drop <= dr;
    @(posedge clk_in);
    raise <= 3'h0;
    drop <= 1'b0;
  endtask

  task automatic wait_act();
    for (int n = 0; n < 20; n++) begin
      @(negedge clk_in);
      act = {accept_nmi_out, accept_mask_out, resume_out};
      if (act !== 3'h0) return;
    end
    err_total++;
    tally_and_finish();
  endtask

  initial begin
    srst_in = 1'b1;
    {avs_read_in, avs_write_in, drop, in_service_in} = 4'h0;
    {interrupts_enabled_in, raise, mask_prio_in, service_prio_in} = 10'h0;
    avs_address_in = 4'h0;
    avs_writedata_in = 32'h0;
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    foreach (ROWS[i]) begin
      r = ROWS[i];
      @(posedge clk_in);
      interrupts_enabled_in <= r.ie;
      in_service_in <= r.svc;
      service_prio_in <= r.sprio;
      mask_prio_in <= r.mprio;
      bus(1'b1, `OFS_CLKSEL, {18'h0, r.cs});
      bus(1'b1, `OFS_MODE, 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h1);
      @(negedge clk_in);
      chk("idle entered", 1, light_idle_mode_out);
      chk("stopped clocks", 0, stop_v);
      chk("kept clocks", r.gate, {interval_timer_clk_en_out, wdt_clk_en_out,
          watch_clk_en_out, csi_clk_en_out,
          uart0_clk_en_out});
      chk("freezes", 4'hf, {adc_freeze_out, dac_freeze_out, state_hold_out,
          realtime_output_freeze_out});
      fire(r.src, 1'b0);
      wait_act();
      chk("wake action", r.act, act);
      @(negedge clk_in);
      chk("back to run", 11'h07f, {light_idle_mode_out, accept_nmi_out,
          accept_mask_out, resume_out, stop_v});
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk("wake cause", {r.cause, 3'h1}, {q[6:4], q[2:0]});
      fire(3'h0, 1'b1);
    end
    interrupts_enabled_in <= 1'b1;
    in_service_in <= 1'b0;
    fire(3'h4, 1'b0);
    bus(1'b1, `OFS_CTRL, 32'h1);
    @(negedge clk_in);
    chk("entry refused", 0, light_idle_mode_out);
    bus(1'b0, `OFS_STATUS, 32'h0);
    chk("refused flag", 1, q[7]);
    fire(3'h0, 1'b1);
    bus(1'b1, `OFS_MODE, 32'h2);
    bus(1'b0, `OFS_MODE, 32'h0);
    chk("mode readback", 32'h2, q);
    bus(1'b1, `OFS_CTRL, 32'h1);
    @(negedge clk_in);
    chk("wrong mode entry", 0, light_idle_mode_out);
    bus(1'b1, `OFS_MODE, 32'h0);
    bus(1'b1, `OFS_CLKSEL, 32'hffff_ffff);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, `OFS_CLKSEL, 32'h0);
    chk("clksel readback", 32'h3fff, q);
    bus(1'b1, `OFS_CTRL, 32'h70);
    bus(1'b1, `OFS_CTRL, 32'h71);
    bus(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl readback", 32'h70, q);
    fire(3'h7, 1'b0);
    repeat (10) @(negedge clk_in);
    chk("masked stay idle", 1, light_idle_mode_out);
    @(posedge clk_in);
    srst_in <= 1'b1;
    @(posedge clk_in);
    srst_in <= 1'b0;
    @(negedge clk_in);
    chk("reset ends idle", 8'h7f, {light_idle_mode_out, stop_v});
    foreach (OFS[k]) begin
      bus(1'b0, OFS[k], 32'h0);
      chk("reset value", RVAL[k], q);
    end
    tally_and_finish();
  end
endmodule

`default_nettype wire
